// [core/tcf_pkg.sv]
//----------------------------------------------------------------------
// Purpose: shared constants and types of the trigger link ends
// Assumes: one 250 MHz pipeline clock for both ends
// Notes: word type sits in the top two bits of each link word
//----------------------------------------------------------------------
package tcf_pkg;

  //--------------------------------------------------------------------
  // clock and framing
  //--------------------------------------------------------------------
  localparam int TCF_CLOCK_MHZ = 250;
  localparam int TCF_FRAME_CYCLES = 4;
  localparam int TCF_FRAME_CNT_W = 2;
  localparam logic [TCF_FRAME_CNT_W-1:0] TCF_FRAME_LAST =
    TCF_FRAME_CNT_W'(TCF_FRAME_CYCLES - 1);

  //--------------------------------------------------------------------
  // link word layout
  //--------------------------------------------------------------------
  localparam int TCF_WORD_W = 16;
  localparam int TCF_TYPE_MSB = 15;
  localparam int TCF_TYPE_LSB = 14;
  localparam int TCF_PAYLOAD_W = 14;
  localparam logic [TCF_PAYLOAD_W-1:0] TCF_TRIG_PAYLOAD = 14'h0001;

  typedef enum logic [1:0] {
    TCF_W_IDLE = 2'b00,
    TCF_W_TRIG = 2'b01,
    TCF_W_CONTENT = 2'b10,
    TCF_W_CTRL = 2'b11
  } tcf_word_type;

  //--------------------------------------------------------------------
  // roles and fan-out
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCF_ROLE_DIST = 2'b00,
    TCF_ROLE_IFACE = 2'b01,
    TCF_ROLE_MASTER = 2'b10
  } tcf_role_type;

  localparam tcf_role_type TCF_ROLE_RESET = TCF_ROLE_IFACE;
  localparam int TCF_MAX_CRATES = 8;
  localparam logic [7:0] TCF_IFACE_OUT_MASK = 8'hf0;
  localparam logic [7:0] TCF_ALL_OUT_MASK = 8'hff;

  //--------------------------------------------------------------------
  // event data serial link
  //--------------------------------------------------------------------
  localparam int TCF_SLOW_MBPS = 250;
  localparam int TCF_FAST_MBPS = 500;
  localparam int TCF_SLOW_BITS = TCF_SLOW_MBPS / TCF_CLOCK_MHZ;
  localparam int TCF_FAST_BITS = TCF_FAST_MBPS / TCF_CLOCK_MHZ;
  localparam int TCF_BIT_CNT_W = 5;
  localparam int TCF_BUF_DEPTH = 2;

endpackage

// [core/tcf_link_if.sv]
//----------------------------------------------------------------------
// Purpose: trigger fiber link between supervisor and trigger module
// Assumes: both ends on clock_i
// Notes: frame marks a word every four cycles
//----------------------------------------------------------------------
`timescale 1ns/100ps
interface tcf_link_if;
  import tcf_pkg::*;

  logic frame;
  logic [TCF_WORD_W-1:0] word;
  logic sync;
  logic busy;

  modport supervisor (
    output frame,
    output word,
    output sync,
    input busy
  );

  modport device (
    input frame,
    input word,
    input sync,
    output busy
  );

endinterface

// [core/tcf_supervisor_end.sv]
//----------------------------------------------------------------------
// Purpose: upstream supervisor end and a two-entry buffer
// Assumes: trig_req_i and content stream on clock_i
// Notes: trigger strobe wins a frame over a content word
//----------------------------------------------------------------------
`timescale 1ns/100ps
module tcf_pair_buffer
  import tcf_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = TCF_BUF_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  initial begin
    if (DEPTH != 2 || WIDTH < 1) $error("pair buffer needs DEPTH 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [1:0] count_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != 2'(DEPTH));
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) mem_q[wr_ptr_q] <= in_data_i;
  end
endmodule // tcf_pair_buffer

module tcf_supervisor_end
  import tcf_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  tcf_link_if.supervisor link,
  input wire logic trig_req_i,
  input wire logic sync_req_i,
  input wire logic [TCF_PAYLOAD_W-1:0] content_i,
  input wire logic content_valid_i,
  output logic content_ready_o,
  output logic trig_sent_o,
  output logic trig_refused_o,
  output logic busy_o
);
  //--------------------------------------------------------------------
  // frame divider
  //--------------------------------------------------------------------
  logic [TCF_FRAME_CNT_W-1:0] frame_cnt_q;
  logic frame_tick;
  assign frame_tick = (frame_cnt_q == TCF_FRAME_LAST);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) frame_cnt_q <= '0;
    else frame_cnt_q <= frame_cnt_q + 1'b1;
  end

  //--------------------------------------------------------------------
  // trigger hold-off and pending requests
  //--------------------------------------------------------------------
  logic trig_pend_q;
  logic sync_pend_q;
  logic trig_take;
  logic send_trig;
  logic [TCF_PAYLOAD_W-1:0] cont_data;
  logic cont_valid;
  logic cont_pop;

  assign busy_o = link.busy;
  assign trig_take = trig_req_i && !link.busy;
  assign send_trig = frame_tick && trig_pend_q;
  assign cont_pop = frame_tick && !trig_pend_q;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) trig_pend_q <= 1'b0;
    else if (trig_take) trig_pend_q <= 1'b1;
    else if (send_trig) trig_pend_q <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) sync_pend_q <= 1'b0;
    else if (sync_req_i) sync_pend_q <= 1'b1;
    else if (frame_tick) sync_pend_q <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      trig_refused_o <= 1'b0;
      trig_sent_o <= 1'b0;
    end else begin
      trig_refused_o <= trig_req_i && link.busy;
      trig_sent_o <= send_trig;
    end
  end

  tcf_pair_buffer #(.WIDTH(TCF_PAYLOAD_W), .DEPTH(TCF_BUF_DEPTH)) u_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_data_i(content_i),
    .in_valid_i(content_valid_i),
    .in_ready_o(content_ready_o),
    .out_data_o(cont_data),
    .out_valid_o(cont_valid),
    .out_ready_i(cont_pop)
  );

  //--------------------------------------------------------------------
  // link word output
  //--------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      link.frame <= 1'b0;
      link.word <= '0;
      link.sync <= 1'b0;
    end else begin
      link.frame <= frame_tick;
      link.sync <= frame_tick && sync_pend_q;
      if (send_trig) link.word <= {TCF_W_TRIG, TCF_TRIG_PAYLOAD};
      else if (cont_pop && cont_valid) link.word <= {TCF_W_CONTENT, cont_data};
      else if (frame_tick) link.word <= {TCF_W_IDLE, 14'h0000};
    end
  end
endmodule // tcf_supervisor_end

// [core/tcf_trigger_end.sv]
//----------------------------------------------------------------------
// Purpose: role dependent trigger, clock and busy routing
// Assumes: pins from outside pass a three stage synchroniser
// Notes: one image serves all three roles
//----------------------------------------------------------------------
`timescale 1ns/100ps
module tcf_trigger_end
  import tcf_pkg::*;
#(
  parameter int NUM_CRATES = TCF_MAX_CRATES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  tcf_link_if.device link,
  input wire logic [1:0] role_i,
  input wire logic aux_frame_i,
  input wire logic [TCF_WORD_W-1:0] aux_word_i,
  input wire logic aux_sync_i,
  input wire logic aux_sel_i,
  output logic aux_busy_o,
  input wire logic bp_trigger_i,
  input wire logic panel_trigger_i,
  input wire logic panel_sync_i,
  input wire logic master_holdoff_i,
  input wire logic sd_busy_i,
  input wire logic rowc_busy_i,
  input wire logic no_switch_i,
  input wire logic [NUM_CRATES-1:0] crate_busy_i,
  output logic [NUM_CRATES-1:0] fiber_active_o,
  output logic fiber_frame_o,
  output logic [TCF_WORD_W-1:0] fiber_word_o,
  output logic fiber_sync_o,
  output logic [NUM_CRATES-1:0] crate_status_o,
  output logic busy_o,
  output logic crate_trigger_o,
  output logic rowc_trigger_o,
  output logic sync_o,
  output logic [TCF_PAYLOAD_W-1:0] content_o,
  output logic content_valid_o,
  input wire logic [TCF_WORD_W-1:0] data_i,
  input wire logic data_valid_i,
  output logic data_ready_o,
  input wire logic fast_rate_i,
  output logic [1:0] sd_serial_o,
  output logic sd_serial_valid_o
);
  initial begin
    if (NUM_CRATES < 1 || NUM_CRATES > TCF_MAX_CRATES)
      $error("NUM_CRATES must be 1 to 8");
  end

  //--------------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------------
  localparam int NPIN = 5 + NUM_CRATES;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_q;

  assign pin_raw = {crate_busy_i, rowc_busy_i, sd_busy_i, panel_sync_i,
                    panel_trigger_i, bp_trigger_i};

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) pin_q[g] <= 1'b0;
      else if (pin_s2_q[g] == pin_s3_q[g]) pin_q[g] <= pin_s3_q[g];
    end
  end

  logic bp_trig;
  logic panel_trig;
  logic panel_sync;
  logic sd_busy;
  logic rowc_busy;
  logic [NUM_CRATES-1:0] crate_busy;
  logic bp_trig_d1_q;
  logic panel_trig_d1_q;
  logic panel_sync_d1_q;
  assign {crate_busy, rowc_busy, sd_busy, panel_sync, panel_trig,
          bp_trig} = pin_q;

  //--------------------------------------------------------------------
  // role register
  //--------------------------------------------------------------------
  tcf_role_type role_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) role_q <= TCF_ROLE_RESET;
    else begin
      unique case (role_i)
        TCF_ROLE_DIST: role_q <= TCF_ROLE_DIST;
        TCF_ROLE_IFACE: role_q <= TCF_ROLE_IFACE;
        TCF_ROLE_MASTER: role_q <= TCF_ROLE_MASTER;
        default: role_q <= TCF_ROLE_IFACE;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // master word generator
  //--------------------------------------------------------------------
  logic [TCF_FRAME_CNT_W-1:0] frame_cnt_q;
  logic m_frame;
  logic m_trig_pend_q;
  logic m_sync_pend_q;
  logic m_frame_q;
  logic m_sync_q;
  logic [TCF_WORD_W-1:0] m_word_q;
  logic merged_busy;
  logic is_master;
  logic m_take;

  assign is_master = (role_q == TCF_ROLE_MASTER);
  assign m_frame = (frame_cnt_q == TCF_FRAME_LAST);
  assign m_take = is_master && panel_trig && !panel_trig_d1_q
                  && !(master_holdoff_i && merged_busy);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      frame_cnt_q <= '0;
      bp_trig_d1_q <= 1'b0;
      panel_trig_d1_q <= 1'b0;
      panel_sync_d1_q <= 1'b0;
    end else begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
      bp_trig_d1_q <= bp_trig;
      panel_trig_d1_q <= panel_trig;
      panel_sync_d1_q <= panel_sync;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) m_trig_pend_q <= 1'b0;
    else if (m_take) m_trig_pend_q <= 1'b1;
    else if (m_frame) m_trig_pend_q <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) m_sync_pend_q <= 1'b0;
    else if (is_master && panel_sync && !panel_sync_d1_q)
      m_sync_pend_q <= 1'b1;
    else if (m_frame) m_sync_pend_q <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      m_frame_q <= 1'b0;
      m_sync_q <= 1'b0;
      m_word_q <= '0;
    end else begin
      m_frame_q <= m_frame && is_master;
      m_sync_q <= m_frame && m_sync_pend_q;
      if (m_frame && m_trig_pend_q) m_word_q <= {TCF_W_TRIG, TCF_TRIG_PAYLOAD};
      else if (m_frame) m_word_q <= {TCF_W_IDLE, 14'h0000};
    end
  end

  //--------------------------------------------------------------------
  // receive source selection and decoder
  //--------------------------------------------------------------------
  logic rx_frame;
  logic rx_sync;
  logic [TCF_WORD_W-1:0] rx_word;
  tcf_word_type rx_type;

  always_comb begin
    rx_frame = link.frame;
    rx_sync = link.sync;
    rx_word = link.word;
    if (is_master) begin
      rx_frame = m_frame_q;
      rx_sync = m_sync_q;
      rx_word = m_word_q;
    end else if (role_q == TCF_ROLE_IFACE && aux_sel_i) begin
      rx_frame = aux_frame_i;
      rx_sync = aux_sync_i;
      rx_word = aux_word_i;
    end
  end

  assign rx_type = tcf_word_type'(rx_word[TCF_TYPE_MSB:TCF_TYPE_LSB]);

  logic dec_trig;
  assign dec_trig = rx_frame && (rx_type == TCF_W_TRIG)
                    && (role_q != TCF_ROLE_DIST);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      crate_trigger_o <= 1'b0;
      rowc_trigger_o <= 1'b0;
      sync_o <= 1'b0;
      content_o <= '0;
      content_valid_o <= 1'b0;
    end else begin
      crate_trigger_o <= dec_trig && !no_switch_i;
      rowc_trigger_o <= dec_trig && no_switch_i;
      sync_o <= rx_sync && (role_q != TCF_ROLE_DIST);
      content_valid_o <= rx_frame && (rx_type == TCF_W_CONTENT)
                         && (role_q != TCF_ROLE_DIST);
      if (rx_frame && rx_type == TCF_W_CONTENT)
        content_o <= rx_word[TCF_PAYLOAD_W-1:0];
    end
  end

  //--------------------------------------------------------------------
  // fiber fan-out
  //--------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      fiber_active_o <= '0;
      fiber_frame_o <= 1'b0;
      fiber_word_o <= '0;
      fiber_sync_o <= 1'b0;
    end else begin
      unique case (role_q)
        TCF_ROLE_DIST: begin
          fiber_active_o <= TCF_ALL_OUT_MASK[NUM_CRATES-1:0];
          fiber_frame_o <= link.frame;
          fiber_sync_o <= link.sync;
          if (link.frame) fiber_word_o <= link.word;
          else if (bp_trig && !bp_trig_d1_q)
            fiber_word_o <= {TCF_W_TRIG, TCF_TRIG_PAYLOAD};
        end
        TCF_ROLE_IFACE: begin
          fiber_active_o <= TCF_IFACE_OUT_MASK[NUM_CRATES-1:0];
          fiber_frame_o <= rx_frame;
          fiber_sync_o <= rx_sync;
          if (rx_frame) fiber_word_o <= rx_word;
        end
        TCF_ROLE_MASTER: begin
          fiber_active_o <= TCF_ALL_OUT_MASK[NUM_CRATES-1:0];
          fiber_frame_o <= m_frame_q;
          fiber_sync_o <= m_sync_q;
          if (m_frame_q) fiber_word_o <= m_word_q;
        end
        default: fiber_active_o <= '0;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // status merge and return
  //--------------------------------------------------------------------
  logic crate_busy_any;
  logic local_busy;
  assign crate_busy_any = |(crate_busy & fiber_active_o);
  assign local_busy = no_switch_i ? rowc_busy : sd_busy;
  assign merged_busy = (role_q == TCF_ROLE_DIST) ? crate_busy_any
                       : (local_busy || crate_busy_any);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      crate_status_o <= '0;
      busy_o <= 1'b0;
      link.busy <= 1'b0;
      aux_busy_o <= 1'b0;
    end else begin
      crate_status_o <= crate_busy;
      busy_o <= merged_busy;
      link.busy <= merged_busy && !is_master;
      aux_busy_o <= merged_busy && (role_q == TCF_ROLE_IFACE);
    end
  end

  //--------------------------------------------------------------------
  // event data serial link
  //--------------------------------------------------------------------
  logic [TCF_WORD_W-1:0] buf_data;
  logic buf_valid;
  logic ser_load;
  logic [TCF_WORD_W-1:0] shift_q;
  logic [TCF_BIT_CNT_W-1:0] bits_left_q;
  logic [TCF_BIT_CNT_W-1:0] step;

  assign step = fast_rate_i ? TCF_BIT_CNT_W'(TCF_FAST_BITS)
                            : TCF_BIT_CNT_W'(TCF_SLOW_BITS);
  assign ser_load = (bits_left_q == '0) && buf_valid;

  tcf_pair_buffer #(.WIDTH(TCF_WORD_W), .DEPTH(TCF_BUF_DEPTH)) u_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_data_i(data_i),
    .in_valid_i(data_valid_i),
    .in_ready_o(data_ready_o),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(ser_load)
  );

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= '0;
      bits_left_q <= '0;
      sd_serial_o <= 2'h0;
      sd_serial_valid_o <= 1'b0;
    end else if (ser_load) begin
      shift_q <= buf_data;
      bits_left_q <= TCF_BIT_CNT_W'(TCF_WORD_W);
      sd_serial_valid_o <= 1'b0;
    end else if (bits_left_q != '0) begin
      sd_serial_valid_o <= 1'b1;
      if (fast_rate_i) begin
        sd_serial_o <= shift_q[TCF_WORD_W-1 -: 2];
        shift_q <= {shift_q[TCF_WORD_W-3:0], 2'h0};
      end else begin
        sd_serial_o <= {1'b0, shift_q[TCF_WORD_W-1]};
        shift_q <= {shift_q[TCF_WORD_W-2:0], 1'b0};
      end
      bits_left_q <= bits_left_q - step;
    end else begin
      sd_serial_valid_o <= 1'b0;
    end
  end
endmodule // tcf_trigger_end

// [testbench/tcf_link_monitor.sv]
//-------
// Purpose: link checks between the two ends
// Assumes: interface signals on clock_i
// Notes: cadence, word and busy relations
//-------
`timescale 1ns/100ps
module tcf_link_monitor
  import tcf_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic frame,
  input wire logic [TCF_WORD_W-1:0] word,
  input wire logic sync,
  input wire logic busy
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [1:0] wt;
  assign wt = word[TCF_TYPE_MSB:TCF_TYPE_LSB];
  a_frame_gap: assert property (frame |=> !frame [*3])
    else $error("frame pulses too close");
  a_frame_period: assert property (frame |-> ##4 frame)
    else $error("frame cadence lost");
  a_word_held: assert property (!frame |-> $stable(word))
    else $error("word moved between frames");
  a_sync_framed: assert property (sync |-> frame)
    else $error("sync off frame");
  a_sync_single: assert property (sync |=> !sync)
    else $error("sync too long");
  a_trig_payload: assert property (
    frame && wt == TCF_W_TRIG |-> word[13:0] == TCF_TRIG_PAYLOAD)
    else $error("bad trigger payload");
  a_idle_zero: assert property (
    frame && wt == TCF_W_IDLE |-> word == 16'h0000)
    else $error("idle word not zero");
  a_busy_holdoff: assert property (
    busy [*8] |=> !(frame && wt == TCF_W_TRIG))
    else $error("trigger sent while busy");
  c_trig: cover property (frame && wt == TCF_W_TRIG);
  c_content: cover property (frame && wt == TCF_W_CONTENT);
  c_sync: cover property (sync);
  c_busy: cover property (busy [*8]);
endmodule // tcf_link_monitor

// [testbench/trigger_clock_fanout_modes_bench.sv]
//-------
// Purpose: bench for supervisor and trigger ends
// Assumes: both ends on one 250 MHz clock
// Notes: sequences of link, pin and stream actions
//-------
`timescale 1ns/100ps
module trigger_clock_fanout_modes_bench
  import tcf_pkg::*;
;
  logic clock_i = 1'h0, reset_i = 1'h1, trig_req_i = 1'h0;
  logic sync_req_i = 1'h0, content_valid_i = 1'h0, data_valid_i = 1'h0;
  logic aux_frame_i = 1'h0, aux_sel_i = 1'h0, panel_trigger_i = 1'h0;
  logic sd_busy_i = 1'h0, rowc_busy_i = 1'h0, no_switch_i = 1'h0;
  logic fast_rate_i = 1'h0;
  logic bp_trigger_i = 1'h0, panel_sync_i = 1'h0, master_holdoff_i = 1'h0;
  logic trig_sent_o, fiber_sync_o;
  logic [1:0] role_i = 2'h1;
  logic [13:0] content_i = 14'h0000;
  logic [15:0] data_i = 16'h0000, aux_word_i = 16'h0000;
  logic [7:0] crate_busy_i = 8'h00;
  logic content_ready_o, trig_refused_o, sbusy, aux_busy_o, fiber_frame_o;
  logic busy_o, crate_trigger_o, rowc_trigger_o, sync_o, content_valid_o;
  logic data_ready_o, sd_serial_valid_o;
  logic [7:0] fiber_active_o, crate_status_o;
  logic [15:0] fiber_word_o, sh;
  logic [13:0] content_o;
  logic [1:0] sd_serial_o;
  logic [15:0] got[$];
  logic [13:0] cq[$];
  logic [7:0] am [4] = '{8'hff, 8'hf0, 8'hff, 8'hf0};
  int n_fail = 0, n_tests = 0, cyc = 0, nb = 0, st = 0, smax = 0;
  int cnt [7];

  tcf_link_if tcf_link_if_i ();
  tcf_supervisor_end tcf_supervisor_end_i (
    .clock_i, .reset_i, .link(tcf_link_if_i.supervisor),
    .trig_req_i, .sync_req_i, .content_i, .content_valid_i,
    .content_ready_o, .trig_sent_o, .trig_refused_o, .busy_o(sbusy));
  tcf_trigger_end tcf_trigger_end_i (
    .clock_i, .reset_i, .link(tcf_link_if_i.device), .role_i,
    .aux_frame_i, .aux_word_i, .aux_sync_i(1'h0), .aux_sel_i, .aux_busy_o,
    .bp_trigger_i, .panel_trigger_i, .panel_sync_i,
    .master_holdoff_i, .sd_busy_i, .rowc_busy_i, .no_switch_i,
    .crate_busy_i, .fiber_active_o, .fiber_frame_o, .fiber_word_o,
    .fiber_sync_o, .crate_status_o, .busy_o, .crate_trigger_o,
    .rowc_trigger_o, .sync_o, .content_o, .content_valid_o, .data_i,
    .data_valid_i, .data_ready_o, .fast_rate_i, .sd_serial_o,
    .sd_serial_valid_o);
  tcf_link_monitor tcf_link_monitor_i (
    .clock_i, .reset_i, .frame(tcf_link_if_i.frame),
    .word(tcf_link_if_i.word), .sync(tcf_link_if_i.sync),
    .busy(tcf_link_if_i.busy));

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  //-------
  // event counters and collectors
  //-------
  always @(posedge clock_i) begin
    cyc++;
    cnt[0] += (crate_trigger_o === 1'h1);
    cnt[1] += (rowc_trigger_o === 1'h1);
    cnt[2] += (trig_refused_o === 1'h1);
    cnt[3] += (fiber_word_o === 16'h4001);
    cnt[4] += (sync_o === 1'h1);
    cnt[5] += (trig_sent_o === 1'h1);
    cnt[6] += (fiber_sync_o === 1'h1);
    if (content_valid_o === 1'h1) cq.push_back(content_o);
    if (sd_serial_valid_o === 1'h1) begin
      if (fast_rate_i) sh = {sh[13:0], sd_serial_o};
      else sh = {sh[14:0], sd_serial_o[0]};
      nb += fast_rate_i ? 2 : 1;
      if (nb == 16) begin
        got.push_back(sh);
        nb = 0;
      end
    end
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end

  //-------
  // tasks
  //-------
  task test_done();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task send();
    cnt = '{default: 0};
    trig_req_i <= 1'h1;
    sync_req_i <= 1'h1;
    tick(1);
    trig_req_i <= 1'h0;
    sync_req_i <= 1'h0;
    tick(12);
  endtask
  task push(input logic c, input logic [15:0] w);
    st = 0;
    if (c) content_i <= w[13:0];
    else data_i <= w;
    content_valid_i <= c;
    data_valid_i <= !c;
    do begin
      @(posedge clock_i);
      st++;
    end while ((c ? content_ready_o : data_ready_o) !== 1'h1 && st < 99);
    if (st > smax) smax = st;
    chk(st < 99, "push stalled");
  endtask

  //-------
  // test sequence
  //-------
  initial begin
    tick(3);
    reset_i <= 1'h0;
    tick(4);
    for (int r = 0; r < 4; r++) begin
      role_i <= 2'(r);
      tick(3);
      chk(fiber_active_o === am[r], "fiber mask");
    end
    role_i <= 2'h1;
    tick(3);
    send();
    chk(cnt[0] == 1 && cnt[4] == 1 && cnt[3] > 0 && cnt[5] == 1
        && cnt[6] == 1, "trigger");
    no_switch_i <= 1'h1;
    send();
    chk(cnt[1] == 1 && cnt[0] == 0, "row c trigger");
    rowc_busy_i <= 1'h1;
    tick(10);
    chk(busy_o === 1'h1 && sbusy === 1'h1, "row c busy");
    rowc_busy_i <= 1'h0;
    no_switch_i <= 1'h0;
    sd_busy_i <= 1'h1;
    tick(10);
    chk(sbusy === 1'h1 && aux_busy_o === 1'h1, "busy up");
    send();
    chk(cnt[2] == 1 && cnt[0] == 0, "refused");
    sd_busy_i <= 1'h0;
    tick(10);
    chk(sbusy === 1'h0, "busy clear");
    for (int i = 0; i < 3; i++) push(1'h1, 16'h0100 + 16'(i));
    content_valid_i <= 1'h0;
    tick(24);
    chk(cq.size() == 3 && cq[2] === 14'h0102, "content");
    aux_sel_i <= 1'h1;
    aux_word_i <= 16'h4001;
    aux_frame_i <= 1'h1;
    cnt = '{default: 0};
    tick(1);
    aux_frame_i <= 1'h0;
    tick(6);
    chk(cnt[0] == 1, "aux trigger");
    aux_sel_i <= 1'h0;
    role_i <= 2'h0;
    crate_busy_i <= 8'h04;
    tick(10);
    chk(crate_status_o === 8'h04 && busy_o === 1'h1, "crate");
    crate_busy_i <= 8'h00;
    tick(10);
    send();
    chk(cnt[0] == 0 && cnt[3] > 0, "fan-out");
    while (tcf_link_if_i.frame !== 1'h1) tick(1);
    cnt = '{default: 0};
    bp_trigger_i <= 1'h1;
    tick(8);
    chk(cnt[3] > 0 && cnt[0] == 0, "backplane trigger");
    bp_trigger_i <= 1'h0;
    role_i <= 2'h2;
    tick(3);
    cnt = '{default: 0};
    panel_trigger_i <= 1'h1;
    panel_sync_i <= 1'h1;
    tick(2);
    panel_trigger_i <= 1'h0;
    panel_sync_i <= 1'h0;
    tick(16);
    chk(cnt[0] == 1 && cnt[3] > 0 && cnt[4] == 1 && cnt[6] == 1,
        "master");
    master_holdoff_i <= 1'h1;
    sd_busy_i <= 1'h1;
    tick(8);
    cnt = '{default: 0};
    panel_trigger_i <= 1'h1;
    tick(2);
    panel_trigger_i <= 1'h0;
    tick(16);
    chk(cnt[0] == 0 && busy_o === 1'h1, "holdoff");
    master_holdoff_i <= 1'h0;
    sd_busy_i <= 1'h0;
    role_i <= 2'h1;
    for (int i = 0; i < 4; i++) push(1'h0, 16'ha5c3 ^ 16'(i));
    data_valid_i <= 1'h0;
    tick(80);
    chk(smax > 1 && got.size() == 4 && got[3] === 16'ha5c0, "slow");
    fast_rate_i <= 1'h1;
    got.delete();
    push(1'h0, 16'h3c96);
    data_valid_i <= 1'h0;
    tick(20);
    chk(got.size() == 1 && got[0] === 16'h3c96, "fast");
    test_done();
  end
endmodule // trigger_clock_fanout_modes_bench
